// ===== rtl/dma_desc_ctrl.sv
// two-channel dma descriptor control with apb registers, arbiter and interrupt
// assumes apb master on pclk, a beat sink (xfer/xfer_ready) and a descriptor fetcher
// Summary of operation
// - each channel holds a 32-bit local start address, reset zero
// - byte count is 23 bits in the low part of the size register
// - ring mode (mode bit 20) processes a descriptor only when its flag is set
// - invalid descriptor: keep polling if mode bit 21 is 0, else stop
// - pointer bit 1 marks last descriptor of the chain
// - pointer bit 2 raises an interrupt at terminal count
// - pointer bits 31:4 hold a 16-byte aligned next descriptor address
// - command bit 0 enables transfers; clearing it pauses the channel
// - command bit 1 starts only an enabled channel; set-only
// - command bit 2 aborts a disabled channel and then sets done
// - command bit 3 clears that channel's pending interrupts
// - status bit 4 reads 1 once finished or aborted
// - arbitration bits 20:19 pick rotating, channel 0 or channel 1 priority
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dma_desc_ctrl (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  xfer_ready,
    output var  dma_desc_pkg::xfer_s   xfer,
    output var  dma_desc_pkg::desc_req_s desc_req,
    input  wire logic                  desc_ack,
    input  wire dma_desc_pkg::desc_s   desc_in,
    output var  logic                  irq
);
    localparam int CW = dma_desc_pkg::CNT_W;

    dma_desc_pkg::chan_regs_s [1:0]        ch, next_ch;
    logic [1:0]                            arb_prio, next_arb_prio;
    logic                                  last_gnt, next_last_gnt;
    logic [dma_desc_pkg::INT_W-1:0]        int_stat, next_int_stat;
    logic [dma_desc_pkg::INT_W-1:0]        int_mask, next_int_mask;
    logic [31:0]                           next_prdata;
    logic                                  next_pready, next_pslverr, next_irq;
    dma_desc_pkg::xfer_s                   next_xfer;
    dma_desc_pkg::desc_req_s               next_desc_req;
    logic [1:0]                            req, gnt, tc_ev, done_ev;
    logic                                  acc_wr, rd_cap, hit_ch, hit_any, wch;
    logic [4:0]                            roff;

    function automatic logic [CW-1:0] step_of(input logic [CW-1:0] cnt);
        step_of = (cnt >= dma_desc_pkg::BEAT_BYTES) ? dma_desc_pkg::BEAT_BYTES : cnt;
    endfunction

    function automatic logic [1:0] pick(input logic [1:0] r, input logic [1:0] pr,
                                        input logic last);
        pick = r;
        if (r == 2'b11) begin
            if (pr == dma_desc_pkg::PRIO_CH0) begin
                pick = 2'b01;
            end else if (pr == dma_desc_pkg::PRIO_CH1) begin
                pick = 2'b10;
            end else begin
                // rotating; the reserved code also rotates so no channel starves
                pick = last ? 2'b01 : 2'b10;
            end
        end
    endfunction

    function automatic logic ring_ok(input dma_desc_pkg::chan_regs_s c);
        ring_ok = !c.ring_en || c.valid;
    endfunction

    // apb decode: ready is held off one access cycle so prdata is a flop
    always_comb begin
        wch     = paddr[5];
        roff    = paddr[4:0];
        hit_ch  = (paddr[31:6] == 26'h000_0000) && (roff <= dma_desc_pkg::OFF_MODE)
                  && (roff[1:0] == 2'b00);
        hit_any = hit_ch || (paddr == dma_desc_pkg::ADDR_ARB)
                  || (paddr == dma_desc_pkg::ADDR_INT_STAT)
                  || (paddr == dma_desc_pkg::ADDR_INT_MASK);
        acc_wr  = psel && penable && pready && pwrite && hit_any;
        rd_cap  = psel && penable && !pready && !pwrite;
        next_pready  = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !hit_any;
        next_prdata  = 32'h0000_0000;
        if (rd_cap && hit_ch) begin
            if (roff == dma_desc_pkg::OFF_LADDR) begin
                next_prdata = ch[wch].laddr;
            end else if (roff == dma_desc_pkg::OFF_SIZE) begin
                next_prdata = {ch[wch].valid, 8'h00, ch[wch].count};
            end else if (roff == dma_desc_pkg::OFF_DPTR) begin
                next_prdata = ch[wch].dptr;
            end else if (roff == dma_desc_pkg::OFF_CSR) begin
                next_prdata = {27'h000_0000, ch[wch].done, 2'b00, ch[wch].start,
                               ch[wch].enable};
            end else begin
                next_prdata[dma_desc_pkg::MODE_RING_EN]   = ch[wch].ring_en;
                next_prdata[dma_desc_pkg::MODE_RING_STOP] = ch[wch].ring_stop;
            end
        end else if (rd_cap && paddr == dma_desc_pkg::ADDR_ARB) begin
            next_prdata = dma_desc_pkg::ARB_RESET;
            next_prdata[dma_desc_pkg::ARB_LSB +: 2] = arb_prio;
        end else if (rd_cap && paddr == dma_desc_pkg::ADDR_INT_STAT) begin
            next_prdata = {28'h000_0000, int_stat};
        end else if (rd_cap && paddr == dma_desc_pkg::ADDR_INT_MASK) begin
            next_prdata = {28'h000_0000, int_mask};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // arbiter between the two channels
    always_comb begin
        for (int c = 0; c < dma_desc_pkg::NUM_CH; c++) begin
            req[c] = (ch[c].state == dma_desc_pkg::CH_RUN) && ch[c].enable && ring_ok(ch[c])
                     && (ch[c].count != '0) && xfer_ready;
        end
        gnt           = pick(req, arb_prio, last_gnt);
        next_last_gnt = gnt[1] ? 1'b1 : (gnt[0] ? 1'b0 : last_gnt);
        next_xfer     = '0;
        if (gnt != 2'b00) begin
            next_xfer.valid   = 1'b1;
            next_xfer.chan    = gnt[1];
            next_xfer.to_host = ch[gnt[1]].dptr[dma_desc_pkg::DP_TO_HOST];
            next_xfer.laddr   = ch[gnt[1]].laddr;
            next_xfer.nbytes  = 3'(step_of(ch[gnt[1]].count));
        end
        next_arb_prio = arb_prio;
        if (acc_wr && paddr == dma_desc_pkg::ADDR_ARB) begin
            next_arb_prio = pwdata[dma_desc_pkg::ARB_LSB +: 2];
        end
    end

    // channel engines, one copy each
    always_comb begin
        next_ch = ch;
        tc_ev   = 2'b00;
        done_ev = 2'b00;
        for (int c = 0; c < dma_desc_pkg::NUM_CH; c++) begin
            case (ch[c].state)
                dma_desc_pkg::CH_RUN: begin
                    if (ch[c].enable) begin
                        if (!ring_ok(ch[c])) begin
                            if (ch[c].ring_stop) begin
                                next_ch[c].state = dma_desc_pkg::CH_IDLE;
                                next_ch[c].start = 1'b0;
                                next_ch[c].done  = 1'b1;
                                done_ev[c]       = 1'b1;
                            end
                        end else if (ch[c].count == '0) begin
                            tc_ev[c] = ch[c].dptr[dma_desc_pkg::DP_TC_IRQ];
                            if (ch[c].dptr[dma_desc_pkg::DP_END_CHAIN]) begin
                                next_ch[c].state = dma_desc_pkg::CH_IDLE;
                                next_ch[c].start = 1'b0;
                                next_ch[c].done  = 1'b1;
                                done_ev[c]       = 1'b1;
                            end else begin
                                next_ch[c].state = dma_desc_pkg::CH_DESC;
                            end
                        end else if (gnt[c]) begin
                            next_ch[c].count = ch[c].count - step_of(ch[c].count);
                            next_ch[c].laddr = ch[c].laddr + 32'(step_of(ch[c].count));
                        end
                    end
                end
                dma_desc_pkg::CH_DESC: begin
                    if (desc_req.valid && desc_ack && desc_req.chan == 1'(c)) begin
                        next_ch[c].laddr = desc_in.laddr;
                        next_ch[c].count = desc_in.size[CW-1:0];
                        next_ch[c].valid = desc_in.size[dma_desc_pkg::SIZE_VALID_BIT];
                        next_ch[c].dptr  = desc_in.dptr;
                        next_ch[c].state = dma_desc_pkg::CH_RUN;
                    end
                end
                default: begin
                end
            endcase
            if (acc_wr && hit_ch && wch == 1'(c)) begin
                if (roff == dma_desc_pkg::OFF_LADDR) begin
                    next_ch[c].laddr = pwdata;
                end else if (roff == dma_desc_pkg::OFF_SIZE) begin
                    next_ch[c].count = pwdata[CW-1:0];
                    next_ch[c].valid = pwdata[dma_desc_pkg::SIZE_VALID_BIT];
                end else if (roff == dma_desc_pkg::OFF_DPTR) begin
                    next_ch[c].dptr = pwdata;
                end else if (roff == dma_desc_pkg::OFF_MODE) begin
                    next_ch[c].ring_en   = pwdata[dma_desc_pkg::MODE_RING_EN];
                    next_ch[c].ring_stop = pwdata[dma_desc_pkg::MODE_RING_STOP];
                end else begin
                    next_ch[c].enable = pwdata[dma_desc_pkg::CS_ENABLE];
                    if (pwdata[dma_desc_pkg::CS_START] && pwdata[dma_desc_pkg::CS_ENABLE]) begin
                        next_ch[c].start = 1'b1;
                        next_ch[c].done  = 1'b0;
                        next_ch[c].state = dma_desc_pkg::CH_RUN;
                    end else if (pwdata[dma_desc_pkg::CS_ABORT]
                                 && !pwdata[dma_desc_pkg::CS_ENABLE]) begin
                        next_ch[c].state = dma_desc_pkg::CH_IDLE;
                        next_ch[c].start = 1'b0;
                        next_ch[c].done  = 1'b1;
                        done_ev[c]       = 1'b1;
                    end
                end
            end
        end
    end

    // interrupt status: bit 2c is terminal count, bit 2c+1 is done; set beats clear
    always_comb begin
        next_int_stat = int_stat;
        if (rd_cap && paddr == dma_desc_pkg::ADDR_INT_STAT) begin
            next_int_stat = '0;
        end
        for (int c = 0; c < dma_desc_pkg::NUM_CH; c++) begin
            if (acc_wr && hit_ch && wch == 1'(c) && roff == dma_desc_pkg::OFF_CSR
                && pwdata[dma_desc_pkg::CS_CLR_INT]) begin
                next_int_stat[2*c +: 2] = 2'b00;
            end
            next_int_stat[2*c]   = next_int_stat[2*c] | tc_ev[c];
            next_int_stat[2*c+1] = next_int_stat[2*c+1] | done_ev[c];
        end
        next_int_mask = int_mask;
        if (acc_wr && paddr == dma_desc_pkg::ADDR_INT_MASK) begin
            next_int_mask = pwdata[dma_desc_pkg::INT_W-1:0];
        end
        next_irq = |(next_int_stat & next_int_mask);
        // descriptor fetch request; channel 0 is served first
        next_desc_req = desc_req;
        if (!desc_req.valid || desc_ack) begin
            next_desc_req = '0;
            for (int c = dma_desc_pkg::NUM_CH - 1; c >= 0; c--) begin
                if (next_ch[c].state == dma_desc_pkg::CH_DESC) begin
                    next_desc_req.valid      = 1'b1;
                    next_desc_req.chan       = 1'(c);
                    next_desc_req.host_space = next_ch[c].dptr[dma_desc_pkg::DP_HOST_SPACE];
                    next_desc_req.addr = {next_ch[c].dptr[31:dma_desc_pkg::DP_NEXT_LSB], 4'h0};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch       <= '0;
            arb_prio <= 2'h0;
            last_gnt <= 1'b0;
            int_stat <= '0;
            int_mask <= '0;
            irq      <= 1'b0;
            xfer     <= '0;
            desc_req <= '0;
        end else if (ce) begin
            ch       <= next_ch;
            arb_prio <= next_arb_prio;
            last_gnt <= next_last_gnt;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            irq      <= next_irq;
            xfer     <= next_xfer;
            desc_req <= next_desc_req;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_laddr_write: assert property (ce && acc_wr && hit_ch && roff == 5'h00 |=>
        ch[$past(wch)].laddr == $past(pwdata)) else $error("local address not stored");
    a_count_write: assert property (ce && acc_wr && hit_ch && roff == 5'h04 |=>
        ch[$past(wch)].count == $past(pwdata[22:0])) else $error("byte count not stored");
    a_ring_poll_hold: assert property (ce && !acc_wr && ch[0].state == dma_desc_pkg::CH_RUN
        && ch[0].enable && ch[0].ring_en && !ch[0].valid && !ch[0].ring_stop
        |=> ch[0].state == dma_desc_pkg::CH_RUN && !(xfer.valid && !xfer.chan))
        else $error("poll broke");
    a_ring_stop_done: assert property (ce && !acc_wr && ch[0].state == dma_desc_pkg::CH_RUN
        && ch[0].enable && ch[0].ring_en && !ch[0].valid && ch[0].ring_stop
        |=> ch[0].done && int_stat[1]) else $error("ring stop not done");
    a_eoc_done: assert property (ce && !acc_wr && ch[1].state == dma_desc_pkg::CH_RUN
        && ch[1].enable && ring_ok(ch[1]) && ch[1].count == '0 && ch[1].dptr[1]
        |=> ch[1].state == dma_desc_pkg::CH_IDLE && ch[1].done) else $error("chain end");
    a_tc_irq_set: assert property (ce && tc_ev[0] |=> int_stat[0])
        else $error("terminal count status lost");
    a_desc_align: assert property (desc_req.valid |-> desc_req.addr ==
        {ch[desc_req.chan].dptr[31:4], 4'h0}) else $error("descriptor address wrong");
    a_pause_nogrant: assert property (!ch[0].enable |-> !gnt[0])
        else $error("disabled channel granted");
    a_start_gated: assert property (ce && acc_wr && hit_ch && roff == 5'h0C && !pwdata[0]
        && ch[$sampled(wch)].state == dma_desc_pkg::CH_IDLE
        |=> ch[$past(wch)].state == dma_desc_pkg::CH_IDLE) else $error("start while disabled");
    a_abort_done: assert property (ce && acc_wr && hit_ch && roff == 5'h0C && pwdata[2]
        && !pwdata[0] |=> ch[$past(wch)].done ##1 irq || !int_mask[2*$past(wch,2)+1])
        else $error("abort without done");
    a_prio_fixed: assert property (req == 2'b11 && arb_prio == 2'h1 |-> gnt == 2'b01)
        else $error("channel 0 priority ignored");
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");

    c_tc_irq: cover property (tc_ev[0] ##[1:4] irq);
    c_desc_fetch: cover property (desc_req.valid && desc_ack);
    c_both_req: cover property (req == 2'b11 && arb_prio == 2'h1);
endmodule
`default_nettype wire

// ===== rtl/dma_desc_pkg.sv
// constants, types and register map of the two-channel dma descriptor control
// assumes a single pclk domain and a 32-bit apb register bus
package dma_desc_pkg;
    // channel n registers sit at CH_STRIDE * n plus the offsets below
    localparam logic [31:0] CH_STRIDE      = 32'h0000_0020;
    localparam logic [4:0]  OFF_LADDR      = 5'h00;
    localparam logic [4:0]  OFF_SIZE       = 5'h04;
    localparam logic [4:0]  OFF_DPTR       = 5'h08;
    localparam logic [4:0]  OFF_CSR        = 5'h0C;
    localparam logic [4:0]  OFF_MODE       = 5'h10;
    localparam logic [31:0] ADDR_ARB       = 32'h0000_0040;
    localparam logic [31:0] ADDR_INT_STAT  = 32'h0000_0044;
    localparam logic [31:0] ADDR_INT_MASK  = 32'h0000_0048;
    // byte count register fields
    localparam int          CNT_W          = 23;
    localparam int          SIZE_VALID_BIT = 31;
    // descriptor pointer fields
    localparam int          DP_HOST_SPACE  = 0;
    localparam int          DP_END_CHAIN   = 1;
    localparam int          DP_TC_IRQ      = 2;
    localparam int          DP_TO_HOST     = 3;
    localparam int          DP_NEXT_LSB    = 4;
    // command/status fields
    localparam int          CS_ENABLE      = 0;
    localparam int          CS_START       = 1;
    localparam int          CS_ABORT       = 2;
    localparam int          CS_CLR_INT     = 3;
    localparam int          CS_DONE        = 4;
    // mode register fields
    localparam int          MODE_RING_EN   = 20;
    localparam int          MODE_RING_STOP = 21;
    // arbitration field and reset image of the whole word
    localparam int          ARB_LSB        = 19;
    localparam logic [31:0] ARB_RESET      = 32'h0020_0000;
    localparam logic [1:0]  PRIO_ROTATE    = 2'h0;
    localparam logic [1:0]  PRIO_CH0       = 2'h1;
    localparam logic [1:0]  PRIO_CH1       = 2'h2;
    // bytes moved per local beat
    localparam logic [CNT_W-1:0] BEAT_BYTES = 23'h00_0004;
    localparam int          NUM_CH         = 2;
    localparam int          INT_W          = 4;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_RUN  = 2'b01,
        CH_DESC = 2'b10
    } ch_state_e;

    typedef struct packed {
        ch_state_e        state;
        logic [31:0]      laddr;
        logic [CNT_W-1:0] count;
        logic             valid;
        logic [31:0]      dptr;
        logic             enable;
        logic             start;
        logic             done;
        logic             ring_en;
        logic             ring_stop;
    } chan_regs_s;

    typedef struct packed {
        logic        valid;
        logic        chan;
        logic        to_host;
        logic [31:0] laddr;
        logic [2:0]  nbytes;
    } xfer_s;

    typedef struct packed {
        logic        valid;
        logic        chan;
        logic        host_space;
        logic [31:0] addr;
    } desc_req_s;

    typedef struct packed {
        logic [31:0] laddr;
        logic [31:0] size;
        logic [31:0] dptr;
    } desc_s;
endpackage

// ===== sim/dma_desc_ctrl_test.sv
// self-checking bench for the two-channel dma descriptor control
// assumes the far-side model answers beats and descriptor fetches
`timescale 1ns/1ps
`default_nettype none
module dma_desc_ctrl_test;
    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [31:0]             paddr = 32'h0;
    logic [31:0]             pwdata = 32'h0;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    xfer_ready;
    logic                    desc_ack;
    logic                    irq;
    logic                    slow = 1'b0;
    logic                    err;
    logic [7:0]              beats0;
    logic [7:0]              beats1;
    logic [31:0]             q;
    logic [31:0]             rnd = 32'h53;
    dma_desc_pkg::xfer_s     xfer;
    dma_desc_pkg::desc_req_s desc_req;
    dma_desc_pkg::desc_s     desc_in;
    dma_desc_pkg::xfer_s     seen;
    dma_desc_pkg::desc_req_s fetch;
    int                      bad_count = 0;
    int                      samples_checked = 0;
    always #2 pclk = ~pclk;
    dma_desc_ctrl dma_desc_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_ready(xfer_ready), .xfer(xfer),
        .desc_req(desc_req), .desc_ack(desc_ack), .desc_in(desc_in), .irq(irq));
    dma_far_model dma_far_model_i (.pclk(pclk), .presetn(presetn), .slow(slow), .xfer(xfer),
        .xfer_ready(xfer_ready), .desc_req(desc_req), .desc_ack(desc_ack), .desc_in(desc_in),
        .seen(seen), .fetch(fetch), .beats0(beats0), .beats1(beats1));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ra(input int ch, input logic [4:0] off);
        return 32'(ch * 32) + {27'h0, off};
    endfunction
    task automatic stop_test();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic run(input int ch, input logic [31:0] sz, input logic [31:0] dp);
        int n;
        apb(1'b1, ra(ch, dma_desc_pkg::OFF_SIZE), sz);
        apb(1'b1, ra(ch, dma_desc_pkg::OFF_DPTR), dp);
        apb(1'b1, ra(ch, dma_desc_pkg::OFF_CSR), 32'h3);
        n = 0;
        do begin
            apb(1'b0, ra(ch, dma_desc_pkg::OFF_CSR), 32'h0);
            n++;
        end while (q[4] !== 1'b1 && n < 400);
        chk("done", 32'h1, {31'h0, q[4]});
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int ch = 0; ch < 2; ch++) begin
            rd("laddr rst", ra(ch, dma_desc_pkg::OFF_LADDR), 32'h0);
            rd("size rst", ra(ch, dma_desc_pkg::OFF_SIZE), 32'h0);
            rd("dptr rst", ra(ch, dma_desc_pkg::OFF_DPTR), 32'h0);
            rd("csr rst", ra(ch, dma_desc_pkg::OFF_CSR), 32'h0);
            rnd = lfsr(rnd);
            apb(1'b1, ra(ch, dma_desc_pkg::OFF_LADDR), rnd);
            rd("laddr", ra(ch, dma_desc_pkg::OFF_LADDR), rnd);
            apb(1'b1, ra(ch, dma_desc_pkg::OFF_SIZE), 32'hFFFF_FFFF);
            rd("size", ra(ch, dma_desc_pkg::OFF_SIZE), 32'h807F_FFFF);
            rnd = lfsr(rnd);
            apb(1'b1, ra(ch, dma_desc_pkg::OFF_DPTR), rnd);
            rd("dptr", ra(ch, dma_desc_pkg::OFF_DPTR), rnd);
        end
        rd("arb rst", dma_desc_pkg::ADDR_ARB, dma_desc_pkg::ARB_RESET);
        apb(1'b1, dma_desc_pkg::ADDR_ARB, 32'hFFFF_FFFF);
        rd("arb rsv", dma_desc_pkg::ADDR_ARB, 32'h0038_0000);
        for (int c = 2; c >= 0; c--) begin
            apb(1'b1, dma_desc_pkg::ADDR_ARB, dma_desc_pkg::ARB_RESET | 32'(c << 19));
            rd("arb", dma_desc_pkg::ADDR_ARB, dma_desc_pkg::ARB_RESET | 32'(c << 19));
        end
        apb(1'b1, 32'h0000_004C, 32'hFFFF_FFFF);
        chk("slverr", 32'h1, {31'h0, err});
        // ch1 alone, mask off: tc and done latch but irq stays low
        apb(1'b1, ra(1, dma_desc_pkg::OFF_LADDR), 32'h1000);
        run(1, 32'h6, 32'h0000_000E);
        chk("beats1", 32'h2, {24'h0, beats1});
        chk("beat", 32'h0002_009A, {seen.laddr[26:0], seen.chan, seen.to_host, seen.nbytes});
        chk("irq off", 32'h0, {31'h0, irq});
        rd("stat", dma_desc_pkg::ADDR_INT_STAT, 32'hC);
        rd("stat clr", dma_desc_pkg::ADDR_INT_STAT, 32'h0);
        // ch0 chain of two descriptors with a stalling sink
        apb(1'b1, dma_desc_pkg::ADDR_INT_MASK, 32'hF);
        slow <= 1'b1;
        run(0, 32'h8, 32'h0000_0105);
        chk("beats0", 32'h3, {24'h0, beats0});
        chk("fetch", 32'h101, {fetch.addr[31:1], fetch.host_space});
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, ra(0, dma_desc_pkg::OFF_CSR), 32'h9);
        repeat (2) @(posedge pclk);
        chk("irq clr", 32'h0, {31'h0, irq});
        // ring mode: an invalid descriptor stops, a valid one moves data
        apb(1'b1, ra(0, dma_desc_pkg::OFF_MODE), 32'h0030_0000);
        run(0, 32'h4, 32'h2);
        chk("ring stop", 32'h3, {24'h0, beats0});
        run(0, 32'h8000_0004, 32'h2);
        chk("ring ok", 32'h4, {24'h0, beats0});
        // ring polling holds an invalid descriptor until aborted
        apb(1'b1, ra(0, dma_desc_pkg::OFF_MODE), 32'h0010_0000);
        apb(1'b1, ra(0, dma_desc_pkg::OFF_SIZE), 32'h4);
        apb(1'b1, ra(0, dma_desc_pkg::OFF_CSR), 32'h3);
        repeat (8) @(posedge pclk);
        rd("polling", ra(0, dma_desc_pkg::OFF_CSR), 32'h3);
        chk("poll beats", 32'h4, {24'h0, beats0});
        apb(1'b1, ra(0, dma_desc_pkg::OFF_CSR), 32'h4);
        // both channels busy with channel 0 favoured: channel 1 waits
        apb(1'b1, dma_desc_pkg::ADDR_ARB, dma_desc_pkg::ARB_RESET | 32'h0008_0000);
        apb(1'b1, ra(0, dma_desc_pkg::OFF_SIZE), 32'h8000_0040);
        apb(1'b1, ra(1, dma_desc_pkg::OFF_SIZE), 32'h40);
        apb(1'b1, ra(0, dma_desc_pkg::OFF_CSR), 32'h3);
        apb(1'b1, ra(1, dma_desc_pkg::OFF_CSR), 32'h3);
        repeat (4) @(posedge pclk);
        chk("prio", 32'h2, {24'h0, beats1});
        repeat (100) @(posedge pclk);
        chk("both", 32'h1412, {16'h0, beats0, beats1});
        // ch1 pause then abort
        apb(1'b1, ra(1, dma_desc_pkg::OFF_SIZE), 32'h400);
        apb(1'b1, ra(1, dma_desc_pkg::OFF_CSR), 32'h3);
        apb(1'b1, ra(1, dma_desc_pkg::OFF_CSR), 32'h0);
        repeat (2) @(posedge pclk);
        rnd = {24'h0, beats1};
        repeat (10) @(posedge pclk);
        chk("paused", rnd, {24'h0, beats1});
        apb(1'b1, ra(1, dma_desc_pkg::OFF_CSR), 32'h4);
        repeat (3) @(posedge pclk);
        apb(1'b0, ra(1, dma_desc_pkg::OFF_CSR), 32'h0);
        chk("abort done", 32'h1, {31'h0, q[4]});
        apb(1'b1, ra(1, dma_desc_pkg::OFF_CSR), 32'h2);
        rd("no start", ra(1, dma_desc_pkg::OFF_CSR), 32'h10);
        stop_test();
    end
endmodule
`default_nettype wire

// ===== sim/dma_far_model.sv
// far-side model: local beat sink and descriptor fetcher
// assumes desc_req holds until desc_ack, one beat per valid cycle
`timescale 1ns/1ps
`default_nettype none
module dma_far_model (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    slow,
    input  wire dma_desc_pkg::xfer_s     xfer,
    output var  logic                    xfer_ready,
    input  wire dma_desc_pkg::desc_req_s desc_req,
    output var  logic                    desc_ack,
    output var  dma_desc_pkg::desc_s     desc_in,
    output var  dma_desc_pkg::xfer_s     seen,
    output var  dma_desc_pkg::desc_req_s fetch,
    output var  logic [7:0]              beats0,
    output var  logic [7:0]              beats1
);
    logic [2:0] tick;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 3'h0;
            xfer_ready <= 1'b0;
            desc_ack <= 1'b0;
            desc_in <= '0;
            seen <= '0;
            fetch <= '0;
            beats0 <= 8'h00;
            beats1 <= 8'h00;
        end else begin
            tick <= tick + 3'h1;
            // slow mode stalls the sink every other cycle
            xfer_ready <= !slow || tick[0];
            desc_ack <= desc_req.valid && !desc_ack && (!slow || tick == 3'h7);
            // next pointer 16-byte aligned, last of chain
            if (desc_req.valid && !desc_ack && (!slow || tick == 3'h7))
                desc_in <= '{32'h0000_0200, 32'h8000_0004, 32'h0000_0302};
            else
                desc_in <= ~desc_in;
            if (xfer.valid)
                seen <= xfer;
            if (desc_req.valid && desc_ack)
                fetch <= desc_req;
            if (xfer.valid && !xfer.chan)
                beats0 <= beats0 + 8'h01;
            if (xfer.valid && xfer.chan)
                beats1 <= beats1 + 8'h01;
        end
    end
endmodule
`default_nettype wire
